/* common/usc_consts.svh */
// constants of the serial transceiver: register indices, reset values, timing
// assumes inclusion by usc_pkg users; definitions only
// Behaviour
// - parity generated and checked only if parity_enable, 7/8-bit frames; resets zero
// - parity select: 00 odd, 01 even, 10 mark, 11 space
// - shared bit is ninth tx bit in 9-bit frames, else parity select low
// - frame length bits: 00 eight, 01 seven, 10 nine data bits; reset zero
// - both length bits set: loop transmitter to receiver, nine-bit framing
// - global_fault sets on any receive error; read only; reset clears
// - complete character copied to holding register, rx_full set, read clears
// - tx_empty set on shifter load, cleared by holding write; resets one
// - overrun, framing, parity flags read only, cleared by status read and reset
// - break_detected stays set until receive status is read
// - rx_ninth_bit holds received ninth bit in nine-bit mode; reset clears
// - attention bit writable; hardware clears it on character with ninth bit one
// - tx_active high while sending, low after final stop bit
// - rx_fault_hold set on framing error or break, low when input high
// - one stop bit sent when two_stop_bits zero, two when one
// - force_break holds serial output low
// - sync_select zero asynchronous, one synchronous; resets zero
// - per-section clock source: zero internal divider, one external pin
// - receive and transmit interrupt enables, active one, reset zero
// - external clock pin as output carries internal baud clock
// - asynchronous serial logic runs at sixteen times baud rate
// - start low rechecked after half bit; bits sampled three times at centre
// - receiver needs only one stop bit whatever transmit setting
// - interrupts pending while flag and its enable both set
// - synchronous mode: transmit on rising, receive on falling clock edge
// - nine-bit framing never generates or checks parity
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH
`define USC_IDX_TXH 8'hb8
`define USC_IDX_RXH 8'hb9
`define USC_IDX_CTL 8'hba
`define USC_IDX_RST 8'hbb
`define USC_IDX_ICS 8'hbc
`define USC_IDX_AUX 8'hbd
`define USC_RST_TX_EMPTY 1'b1
`define USC_BAUD_DIV 16'h0005
`define USC_HALF_BIT 4'h7
`define USC_LAST_TICK 4'hf
`define USC_SAMPLE_A 4'hd
`define USC_SAMPLE_B 4'he
`endif

/* common/usc_pkg.sv */
// types of the serial transceiver
// assumes a classic wishbone master with 32-bit data and byte addresses
package usc_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } usc_wb_req_t;
  typedef struct packed {
    logic parity_enable;
    logic psel_hi;
    logic tx9_plo;
    logic flen_hi;
    logic flen_lo;
  } usc_ctl_t;
  typedef struct packed {
    logic two_stop;
    logic force_break;
    logic tx_pin_en;
    logic sync_sel;
    logic rx_ext;
    logic tx_ext;
    logic rx_ie;
    logic tx_ie;
  } usc_ics_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} usc_tx_st_t;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_STOP  = 5'b01000,
    RX_WAIT  = 5'b10000
  } usc_rx_st_t;
endpackage : usc_pkg

/* rtl/usc_top.sv */
// serial transceiver: wishbone registers, transmitter, oversampling receiver
// assumes synchronous pin inputs and a single clock domain
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "usc_consts.svh"
module usc_top
  import usc_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = `USC_BAUD_DIV
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire usc_wb_req_t wb_req,
  output logic             wb_ack_q,
  output logic [31:0]      wb_dat_q,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_q,
  output logic             serial_out_en_q,
  input  wire logic        ext_clock_pin_i,
  output logic             ext_clock_o_q,
  output logic             ext_clock_oe_q,
  output logic             rx_irq_q,
  output logic             tx_irq_q
);

  function automatic logic hit(input logic [9:0] a, input logic [7:0] r);
    return a == {2'b00, r};
  endfunction : hit

  function automatic logic par_of(input logic [7:0] d, input logic sev, input logic [1:0] sel);
    logic x;
    x = ^(sev ? {1'b0, d[6:0]} : d);
    case (sel)
      2'b00:   return ~x;
      2'b01:   return x;
      2'b10:   return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : par_of

  usc_ctl_t    ctl_q;
  usc_ics_t    ics_q;
  usc_tx_st_t  tx_st_q;
  usc_rx_st_t  rx_st_q;
  logic        aux_oe_q;
  logic [7:0]  txh_q;
  logic [7:0]  rxh_q;
  logic        tx_empty_q;
  logic        rx_full_q;
  logic        err_q;
  logic        doe_q;
  logic        fe_q;
  logic        pe_q;
  logic        bd_q;
  logic        rx_ninth_bit_q;
  logic        attention_mode_q;
  logic        rx_fault_q;
  logic [15:0] div_q;
  logic        int_clk_q;
  logic        ext_q;
  logic [11:0] tsh_q;
  logic [3:0]  tcnt_q;
  logic [3:0]  tbits_q;
  logic [9:0]  rsh_q;
  logic [3:0]  rcnt_q;
  logic [3:0]  rbits_q;
  logic        s1_q;
  logic        s2_q;

  logic        acc;
  logic        wr;
  logic        rd;
  logic [9:0]  idx;
  logic [7:0]  rdat;
  logic        wr_txh;
  logic        rd_rxh;
  logic        rd_rst;
  logic        nine;
  logic        seven;
  logic        loop;
  logic        par_on;
  logic        sync;
  logic        int_tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        tx_ev;
  logic        rx_rise;
  logic        rx_fall;
  logic        rx_ev;
  logic        ext_bit;
  logic [11:0] tfrm;
  logic [3:0]  tlen;
  logic        tstep;
  logic        tlast;
  logic        load;
  logic        tx_line;
  logic        rxin;
  logic        maj;
  logic        bit_done;
  logic        bit_val;
  logic [3:0]  rn;
  logic [9:0]  ra;
  logic [7:0]  rd8;
  logic        rext;
  logic        rx_done;
  logic        accept;
  logic        fe_ev;
  logic        bd_ev;
  logic        pe_ev;
  logic        ov_ev;

  // register bus: one access per request, answered one edge later
  assign acc    = wb_req.cyc & wb_req.stb & ~wb_ack_q;
  assign idx    = wb_req.adr[11:2];
  assign wr     = acc & wb_req.we & wb_req.sel[0];
  assign rd     = acc & ~wb_req.we;
  assign wr_txh = wr & hit(idx, `USC_IDX_TXH);
  assign rd_rxh = rd & hit(idx, `USC_IDX_RXH);
  assign rd_rst = rd & hit(idx, `USC_IDX_RST);

  always_comb begin
    rdat = 8'h00;
    if (hit(idx, `USC_IDX_TXH)) rdat = txh_q;
    if (hit(idx, `USC_IDX_RXH)) rdat = rxh_q;
    if (hit(idx, `USC_IDX_CTL)) rdat = {ctl_q, err_q, rx_full_q, tx_empty_q};
    if (hit(idx, `USC_IDX_RST)) rdat = {doe_q, fe_q, pe_q, bd_q, rx_ninth_bit_q, attention_mode_q, tx_st_q == TX_SHIFT, rx_fault_q};
    if (hit(idx, `USC_IDX_ICS)) rdat = ics_q;
    if (hit(idx, `USC_IDX_AUX)) rdat = {7'h00, aux_oe_q};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= acc;
      wb_dat_q <= acc ? {24'h00_0000, rdat} : 32'h0000_0000;
    end
  end

  // control registers; all enables and modes clear on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q    <= '0;
      ics_q    <= '0;
      aux_oe_q <= 1'b0;
      txh_q    <= 8'h00;
    end else begin
      if (wr && hit(idx, `USC_IDX_CTL)) ctl_q <= wb_req.dat[7:3];
      if (wr && hit(idx, `USC_IDX_ICS)) ics_q <= wb_req.dat[7:0];
      if (wr && hit(idx, `USC_IDX_AUX)) aux_oe_q <= wb_req.dat[0];
      if (wr_txh) txh_q <= wb_req.dat[7:0];
    end
  end

  // frame format decode
  assign nine   = ctl_q.flen_hi;
  assign seven  = ~ctl_q.flen_hi & ctl_q.flen_lo;
  assign loop   = ctl_q.flen_hi & ctl_q.flen_lo;
  assign par_on = ctl_q.parity_enable & ~nine;
  assign sync   = ics_q.sync_sel;

  // internal baud clock; a full period spans two divider wraps
  assign int_tick = div_q == BAUD_DIV - 16'h0001;
  assign ext_rise = ext_clock_pin_i & ~ext_q;
  assign ext_fall = ~ext_clock_pin_i & ext_q;
  assign tx_ev    = ics_q.tx_ext ? ext_rise : int_tick & ~int_clk_q;
  assign rx_rise  = ics_q.rx_ext ? ext_rise : int_tick & ~int_clk_q;
  assign rx_fall  = ics_q.rx_ext ? ext_fall : int_tick & int_clk_q;
  assign rx_ev    = sync ? rx_fall : rx_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q          <= 16'h0000;
      int_clk_q      <= 1'b0;
      ext_q          <= 1'b0;
      ext_clock_o_q  <= 1'b0;
      ext_clock_oe_q <= 1'b0;
    end else begin
      div_q          <= int_tick ? 16'h0000 : div_q + 16'h0001;
      int_clk_q      <= int_clk_q ^ int_tick;
      ext_q          <= ext_clock_pin_i;
      ext_clock_o_q  <= int_clk_q;
      ext_clock_oe_q <= aux_oe_q;
    end
  end

  // transmitter: frame is start, data lsb first, ninth or parity, stops
  always_comb begin
    ext_bit = nine ? ctl_q.tx9_plo : par_of(txh_q, seven, {ctl_q.psel_hi, ctl_q.tx9_plo});
    tfrm    = 12'hfff;
    if (seven) begin
      tfrm[8:0] = {par_on ? ext_bit : 1'b1, txh_q[6:0], 1'b0};
    end else begin
      tfrm[9:0] = {(par_on | nine) ? ext_bit : 1'b1, txh_q, 1'b0};
    end
    tlen = (seven ? 4'h8 : 4'h9) + {3'b000, par_on | nine} + 4'h1 + {3'b000, ics_q.two_stop};
  end

  // async bits last sixteen ticks, sync bits one rising edge
  assign tstep   = tx_st_q == TX_SHIFT && tx_ev && (sync || tcnt_q == `USC_LAST_TICK);
  assign tlast   = tstep && tbits_q == 4'h1;
  // a load never meets a holding write in the same cycle, so no byte is lost
  assign load    = ~tx_empty_q & ~wr_txh & (tx_st_q == TX_IDLE | tlast);
  assign tx_line = tx_st_q == TX_SHIFT ? tsh_q[0] : 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= TX_IDLE;
      tsh_q   <= 12'hfff;
      tcnt_q  <= 4'h0;
      tbits_q <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (load) begin
            tx_st_q <= TX_SHIFT;
            tsh_q   <= tfrm;
            tbits_q <= tlen;
            tcnt_q  <= 4'h0;
          end
        end
        TX_SHIFT: begin
          if (tx_ev) tcnt_q <= tcnt_q + 4'h1;
          if (tstep) begin
            tsh_q   <= {1'b1, tsh_q[11:1]};
            tbits_q <= tbits_q - 4'h1;
          end
          if (tlast && load) begin
            tsh_q   <= tfrm;
            tbits_q <= tlen;
            tcnt_q  <= 4'h0;
          end else if (tlast) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_q       <= `USC_RST_TX_EMPTY;
      serial_out_pin_q <= 1'b1;
      serial_out_en_q  <= 1'b0;
      tx_irq_q         <= 1'b0;
      rx_irq_q         <= 1'b0;
    end else begin
      if (load) tx_empty_q <= 1'b1;
      else if (wr_txh) tx_empty_q <= 1'b0;
      serial_out_pin_q <= tx_line & ~ics_q.force_break;
      serial_out_en_q  <= ics_q.tx_pin_en;
      tx_irq_q         <= tx_empty_q & ics_q.tx_ie;
      rx_irq_q         <= rx_full_q & ics_q.rx_ie;
    end
  end

  // receiver
  assign rxin     = loop ? tx_line & ~ics_q.force_break : serial_in_pin;
  assign maj      = (s1_q & s2_q) | (s1_q & rxin) | (s2_q & rxin);
  assign bit_done = sync ? rx_fall : rx_rise && rcnt_q == `USC_LAST_TICK;
  assign bit_val  = sync ? rxin : maj;
  assign rn       = (seven ? 4'h7 : 4'h8) + {3'b000, par_on | nine};
  assign ra       = rsh_q >> (4'ha - rn);
  assign rd8      = seven ? {1'b0, ra[6:0]} : ra[7:0];
  assign rext     = seven ? ra[7] : ra[8];
  assign rx_done  = rx_st_q == RX_STOP && bit_done;
  // in attention mode with nine-bit frames only characters with the ninth bit set reach software
  assign accept   = rx_done & ~(attention_mode_q & nine & ~rext);
  assign fe_ev    = rx_done & ~bit_val;
  assign bd_ev    = fe_ev & (ra == 10'h000);
  assign pe_ev    = rx_done & par_on & (rext != par_of(rd8, seven, {ctl_q.psel_hi, ctl_q.tx9_plo}));
  assign ov_ev    = accept & rx_full_q & ~rd_rxh;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE;
      rcnt_q  <= 4'h0;
      rbits_q <= 4'h0;
      rsh_q   <= 10'h000;
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
    end else begin
      if (rx_rise) rcnt_q <= rcnt_q + 4'h1;
      if (rx_rise && rcnt_q == `USC_SAMPLE_A) s1_q <= rxin;
      if (rx_rise && rcnt_q == `USC_SAMPLE_B) s2_q <= rxin;
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_ev && !rxin) begin
            rcnt_q  <= 4'h0;
            rbits_q <= 4'h0;
            rx_st_q <= sync ? RX_DATA : RX_START;
          end
        end
        RX_START: begin
          // recheck after half a bit filters glitches on the line
          if (rx_rise && rcnt_q == `USC_HALF_BIT) begin
            rcnt_q  <= 4'h0;
            rx_st_q <= rxin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bit_done) begin
            rsh_q   <= {bit_val, rsh_q[9:1]};
            rbits_q <= rbits_q + 4'h1;
            if (rbits_q == rn - 4'h1) rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          // a low stop waits for the line to idle before hunting again
          if (bit_done) rx_st_q <= bit_val ? RX_IDLE : RX_WAIT;
        end
        RX_WAIT: begin
          if (rxin) rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // receive status; a new event beats a clearing read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxh_q      <= 8'h00;
      rx_full_q  <= 1'b0;
      rx_ninth_bit_q    <= 1'b0;
      attention_mode_q     <= 1'b0;
      doe_q      <= 1'b0;
      fe_q       <= 1'b0;
      pe_q       <= 1'b0;
      bd_q       <= 1'b0;
      err_q      <= 1'b0;
      rx_fault_q <= 1'b0;
    end else begin
      if (accept) rxh_q <= rd8;
      rx_full_q <= accept | (rx_full_q & ~rd_rxh);
      if (accept && nine) rx_ninth_bit_q <= rext;
      if (wr && hit(idx, `USC_IDX_RST)) attention_mode_q <= wb_req.dat[2];
      else if (rx_done && nine && rext) attention_mode_q <= 1'b0;
      doe_q      <= ov_ev | (doe_q & ~rd_rst);
      fe_q       <= fe_ev | (fe_q & ~rd_rst);
      pe_q       <= pe_ev | (pe_q & ~rd_rst);
      bd_q       <= bd_ev | (bd_q & ~rd_rst);
      err_q      <= ov_ev | fe_ev | pe_ev | bd_ev | (err_q & ~rd_rst);
      rx_fault_q <= fe_ev | bd_ev | (rx_fault_q & ~rxin);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_tx_load;
    (tx_st_q == TX_IDLE && !tx_empty_q && !wr_txh) |=> (tx_empty_q && tx_st_q == TX_SHIFT) ##1 !serial_out_pin_q;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("holding byte not moved to shifter");

  property p_tx_write;
    wr_txh && !load |=> !tx_empty_q;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("holding write left tx_empty set");

  property p_break;
    ics_q.force_break |=> !serial_out_pin_q;
  endproperty
  a_break: assert property (p_break) else $error("break not driven low");

  property p_err;
    err_q == (doe_q | fe_q | pe_q | bd_q);
  endproperty
  a_err: assert property (p_err) else $error("global fault disagrees with flags");

  property p_stat_clear;
    rd_rst && !rx_done |=> !fe_q && !pe_q && !doe_q && !bd_q;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status read kept an error flag");

  property p_rx_read;
    rd_rxh && !rx_done |=> !rx_full_q;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("holding read kept rx_full");

  property p_tx_irq;
    tx_empty_q && ics_q.tx_ie |=> tx_irq_q;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt not pending");

  property p_fault_hold;
    rx_fault_q && rxin && !rx_done |=> !rx_fault_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault hold stuck with input high");

  property p_nine_par;
    nine |-> !pe_ev;
  endproperty
  a_nine_par: assert property (p_nine_par) else $error("parity checked in nine-bit frame");

endmodule : usc_top

/* verification/usc_remote.sv */
// remote serial transceiver: sends frames on the device input, captures frames from its output
// assumes the bench clock and a bit time of BIT clock cycles
`timescale 1ns/100ps
module usc_remote #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  input  wire logic line_from_dut,
  input  wire logic line_en,
  output logic      line_to_dut
);
  logic line_lvl;
  // undriven output pin floats to its pull-up, so an idle frame never looks like a start
  assign line_lvl = line_en ? line_from_dut : 1'b1;
  initial line_to_dut = 1'b1;

  // caller stands just after a rising edge; bits go out lsb first
  task send(input logic [11:0] bits, input int n, input logic rest);
    for (int i = 0; i < n; i++) begin
      line_to_dut <= bits[i];
      repeat (BIT) @(posedge clk);
    end
    line_to_dut <= rest;
  endtask : send

  // low pulse shorter than half a bit, which a receiver must not take for a start
  task glitch(input int len);
    line_to_dut <= 1'b0;
    repeat (len) @(posedge clk);
    line_to_dut <= 1'b1;
  endtask : glitch

  // samples n bit centres from the start edge on; returns at the last centre
  task grab(input int n, output logic [11:0] bits);
    int w;
    w = 0;
    bits = '0;
    while (line_lvl !== 1'b0) begin
      @(posedge clk);
      w++;
      if (w > 4000) begin
        bits = 'x;
        return;
      end
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_lvl;
      if (i < n - 1) repeat (BIT) @(posedge clk);
    end
  endtask : grab
endmodule : usc_remote

/* verification/usc_top_bench.sv */
// self-checking bench of the serial transceiver: registers, transmit, receive, errors, loopback
// assumes usc_remote on the serial pins and BAUD_DIV of one, so a bit lasts 32 clocks
`timescale 1ns/100ps
`include "usc_consts.svh"
module usc_top_bench
  import usc_pkg::*;
;
  localparam int BIT = 32;
  localparam logic [7:0] TXH = `USC_IDX_TXH;
  localparam logic [7:0] RXH = `USC_IDX_RXH;
  localparam logic [7:0] CTL = `USC_IDX_CTL;
  localparam logic [7:0] RST = `USC_IDX_RST;
  localparam logic [7:0] ICS = `USC_IDX_ICS;
  localparam logic [7:0] AUX = `USC_IDX_AUX;
  logic        clk, rst_n, wb_ack_q, serial_in_pin, serial_out_pin_q, serial_out_en_q;
  logic        ext_clock_pin_i, ext_clock_o_q, ext_clock_oe_q, rx_irq_q, tx_irq_q;
  logic [31:0] wb_dat_q;
  usc_wb_req_t wb_req;
  logic [7:0]  r;
  int          num_errors, check_count, cycles;

  usc_top #(.BAUD_DIV(16'h0001)) usc_top_i (.clk(clk), .rst_n(rst_n), .wb_req(wb_req), .wb_ack_q(wb_ack_q),
    .wb_dat_q(wb_dat_q), .serial_in_pin(serial_in_pin), .serial_out_pin_q(serial_out_pin_q),
    .serial_out_en_q(serial_out_en_q), .ext_clock_pin_i(ext_clock_pin_i), .ext_clock_o_q(ext_clock_o_q),
    .ext_clock_oe_q(ext_clock_oe_q), .rx_irq_q(rx_irq_q), .tx_irq_q(tx_irq_q));
  usc_remote #(.BIT(BIT)) usc_remote_i (.clk(clk), .line_from_dut(serial_out_pin_q),
    .line_en(serial_out_en_q), .line_to_dut(serial_in_pin));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end

  task summarize;
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled, released at that edge
  task xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {2'b00, idx, 2'b00}, sel: 4'h1, dat: {24'h00_0000, wd}};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_q !== 1'b1 && n < 20);
    rd = wb_dat_q[7:0];
    wb_req <= '0;
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, r);
  endtask : wr

  task ck(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    xfer(1'b0, idx, 8'h00, v);
    chk(v & m, e);
  endtask : ck

  task t_regs;
    logic seen0, seen1;
    ck(CTL, 8'hff, 8'h01);
    ck(RST, 8'hff, 8'h00);
    ck(ICS, 8'hff, 8'h00);
    ck(8'h20, 8'hff, 8'h00);
    wr(CTL, 8'h07);
    ck(CTL, 8'hff, 8'h01);
    wr(RST, 8'hff);
    ck(RST, 8'hff, 8'h04);
    wr(RST, 8'h00);
    wr(ICS, 8'h9f);
    ck(ICS, 8'hff, 8'h9f);
    chk(tx_irq_q, 1'b1);
    wr(ICS, 8'h00);
    repeat (2) @(posedge clk);
    chk(tx_irq_q, 1'b0);
    wr(AUX, 8'h01);
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (6) begin
      @(posedge clk);
      seen0 |= (ext_clock_o_q === 1'b0);
      seen1 |= (ext_clock_o_q === 1'b1);
    end
    chk({ext_clock_oe_q, seen0, seen1}, 3'b111);
    wr(AUX, 8'h00);
  endtask : t_regs

  task t_tx(input logic [7:0] c, input logic [7:0] s, input logic [7:0] d, input int n, input logic [11:0] e);
    logic [11:0] got;
    wr(ICS, s);
    wr(CTL, c);
    wr(TXH, d);
    usc_remote_i.grab(n, got);
    chk(got, e);
    ck(RST, 8'h02, 8'h02);
    repeat (BIT) @(posedge clk);
    ck(RST, 8'h02, 8'h00);
  endtask : t_tx

  task t_b2b;
    logic [11:0] got;
    wr(ICS, 8'h20);
    wr(CTL, 8'h00);
    wr(TXH, 8'h81);
    wr(TXH, 8'h42);
    usc_remote_i.grab(10, got);
    chk(got, {2'b01, 8'h81, 1'b0});
    ck(CTL, 8'hff, 8'h00);
    usc_remote_i.grab(10, got);
    chk(got, {2'b01, 8'h42, 1'b0});
    ck(CTL, 8'h01, 8'h01);
    wr(ICS, 8'h60);
    repeat (2) @(posedge clk);
    chk({serial_out_en_q, serial_out_pin_q}, 2'b10);
    wr(ICS, 8'h20);
    repeat (2) @(posedge clk);
    chk(serial_out_pin_q, 1'b1);
  endtask : t_b2b

  task t_rx;
    wr(ICS, 8'h02);
    usc_remote_i.glitch(8);
    repeat (12 * BIT) @(posedge clk);
    ck(CTL, 8'h02, 8'h00);
    usc_remote_i.send({2'b11, 8'h3c, 1'b0}, 10, 1'b1);
    repeat (4) @(posedge clk);
    ck(CTL, 8'hff, 8'h03);
    chk(rx_irq_q, 1'b1);
    ck(RXH, 8'hff, 8'h3c);
    repeat (2) @(posedge clk);
    chk(rx_irq_q, 1'b0);
    ck(CTL, 8'h02, 8'h00);
    wr(ICS, 8'h80);
    usc_remote_i.send({1'b1, 8'h11, 1'b0}, 10, 1'b1);
    usc_remote_i.send({1'b1, 8'h22, 1'b0}, 10, 1'b1);
    repeat (4) @(posedge clk);
    ck(CTL, 8'hff, 8'h07);
    ck(RST, 8'hf0, 8'h80);
    ck(RXH, 8'hff, 8'h22);
    wr(CTL, 8'ha0);
    usc_remote_i.send({2'b10, 8'h01, 1'b0}, 11, 1'b1);
    repeat (4) @(posedge clk);
    ck(RST, 8'hf0, 8'h20);
    ck(RST, 8'hf0, 8'h00);
    ck(RXH, 8'h00, 8'h00);
  endtask : t_rx

  task t_faults;
    wr(CTL, 8'h00);
    usc_remote_i.send(12'h000, 10, 1'b0);
    repeat (BIT) @(posedge clk);
    ck(CTL, 8'h04, 8'h04);
    ck(RST, 8'hf1, 8'h51);
    ck(RST, 8'hf1, 8'h01);
    usc_remote_i.send(12'h001, 1, 1'b1);
    ck(RST, 8'h01, 8'h00);
    ck(RXH, 8'h00, 8'h00);
    usc_remote_i.send({2'b00, 8'h55, 1'b0}, 10, 1'b1);
    repeat (4) @(posedge clk);
    ck(RST, 8'hf0, 8'h40);
    ck(RXH, 8'h00, 8'h00);
  endtask : t_faults

  task t_loop;
    wr(ICS, 8'h00);
    wr(CTL, 8'h38);
    wr(RST, 8'h04);
    wr(TXH, 8'h5a);
    repeat (13 * BIT) @(posedge clk);
    ck(RST, 8'h0e, 8'h08);
    ck(RXH, 8'hff, 8'h5a);
    wr(CTL, 8'h18);
    wr(RST, 8'h04);
    wr(TXH, 8'h33);
    repeat (13 * BIT) @(posedge clk);
    ck(CTL, 8'h02, 8'h00);
    ck(RST, 8'h0c, 8'h0c);
    wr(RST, 8'h00);
  endtask : t_loop

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wb_req = '0;
    ext_clock_pin_i = 1'b0;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    for (int s = 0; s < 4; s++) begin
      t_tx(8'h80 | 8'(s << 5), (s == 3) ? 8'ha0 : 8'h20, 8'h0b, (s == 3) ? 12 : 11,
           {(s == 3) ? 2'b11 : 2'b01, 4'b0110 >> s & 4'h1 ? 1'b1 : 1'b0, 8'h0b, 1'b0});
    end
    t_tx(8'h08, 8'h20, 8'h7f, 9, {3'b000, 1'b1, 7'h7f, 1'b0});
    t_tx(8'h00, 8'h20, 8'h96, 10, {2'b01, 8'h96, 1'b0});
    t_tx(8'hb0, 8'h20, 8'h00, 11, {1'b0, 2'b11, 8'h00, 1'b0});
    t_b2b();
    t_rx();
    t_faults();
    t_loop();
    summarize();
  end
endmodule : usc_top_bench
